// ===== watchdog_map.vh
// Register offsets, field positions, reset values and timing counts of the watchdog
`ifndef WATCHDOG_MAP_VH
`define WATCHDOG_MAP_VH
// Control register index (printed offset) and its byte address
`define WDOG_CTRL_INDEX 8'h8F
`define WDOG_CTRL_ADDR 10'h23C
// Interrupt status and mask registers
`define WDOG_STAT_ADDR 10'h240
`define WDOG_MASK_ADDR 10'h244
// Live counter readback
`define WDOG_COUNT_ADDR 10'h248
// Control field positions
`define WDOG_ENABLE_BIT 7
`define WDOG_RESTART_BIT 6
`define WDOG_IDLE_RUN_BIT 5
`define WDOG_SEL_MSB 2
`define WDOG_SEL_LSB 0
// Status field positions
`define WDOG_ST_TIMEOUT 0
`define WDOG_ST_RESTART 1
// Reset values
`define WDOG_CTRL_RESET 8'h00
`define WDOG_MASK_RESET 2'h0
// Counter geometry and clocks per instruction cycle
`define WDOG_COUNT_BITS 14
`define WDOG_PRESCALE_BITS 8
`define WDOG_CLKS_PER_TICK 12
`define WDOG_CYC_BITS 4
// Length of the system reset pulse in clocks
`define WDOG_RESET_PULSE 8'h10
`endif

// ===== prescale_divider.v
// Prescaler counter with a selectable tap, one-cycle pulse per division
module prescale_divider (
  input wire mclk, // System clock
  input wire resetn, // Asynchronous reset, active low
  input wire clear, // Synchronous clear of the divider
  input wire advance, // Count enable, one per tick
  input wire [2:0] select, // Division select code
  output reg pulse // One-cycle pulse at the selected ratio
);
`include "watchdog_map.vh"

  reg [`WDOG_PRESCALE_BITS-1:0] count; // Free-running divider chain
  reg [`WDOG_PRESCALE_BITS-1:0] last; // Terminal value for this ratio
  wire [`WDOG_PRESCALE_BITS-1:0] next_count; // Incremented value
  assign next_count = count + 8'h01;

  // Non-binary code order of the select field
  always @* begin
    case (select)
      3'h0: last = 8'h01;
      3'h2: last = 8'h03;
      3'h1: last = 8'h07;
      3'h3: last = 8'h0F;
      3'h4: last = 8'h1F;
      3'h5: last = 8'h3F;
      3'h6: last = 8'h7F;
      default: last = 8'hFF;
    endcase
  end

  // Divider chain and tap compare
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      count <= 8'h00;
      pulse <= 1'b0;
    end else if (clear) begin
      count <= 8'h00;
      pulse <= 1'b0;
    end else if (advance) begin
      // A change of select mid-count may give one short or long period
      pulse <= (count >= last);
      count <= (count >= last) ? 8'h00 : next_count;
    end else begin
      pulse <= 1'b0;
    end
  end
endmodule // prescale_divider

// ===== tick_divider.v
// Divides the system clock into one instruction-cycle enable pulse
module tick_divider (
  input wire mclk, // System clock
  input wire resetn, // Asynchronous reset, active low
  input wire run, // Divider runs while high
  output reg tick // One-cycle pulse every instruction cycle
);
`include "watchdog_map.vh"

  reg [`WDOG_CYC_BITS-1:0] phase; // Position within the cycle
  localparam [`WDOG_CYC_BITS-1:0] last_phase = `WDOG_CLKS_PER_TICK - 1;

  // Phase counter; stopped divider holds its phase
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      phase <= 4'h0;
      tick <= 1'b0;
    end else if (run) begin
      tick <= (phase == last_phase);
      phase <= (phase == last_phase) ? 4'h0 : phase + 4'h1;
    end else begin
      tick <= 1'b0;
    end
  end
endmodule // tick_divider

// ===== watchdog_timer.v
// Watchdog timer with Wishbone register access and an event interrupt
//
// The Wishbone interface to the registers was left to the implementer.
`include "watchdog_map.vh"

module watchdog_timer (
  input wire mclk, // System clock, 100 MHz
  input wire resetn, // Asynchronous system reset, active low
  input wire idle_mode, // Processor is in idle mode
  input wire wb_cyc_i, // Wishbone cycle
  input wire wb_stb_i, // Wishbone strobe
  input wire wb_we_i, // Wishbone write enable
  input wire [11:0] wb_adr_i, // Wishbone byte address
  input wire [3:0] wb_sel_i, // Wishbone byte selects
  input wire [31:0] wb_dat_i, // Wishbone write data
  output reg [31:0] wb_dat_o, // Wishbone read data
  output reg wb_ack_o, // Wishbone acknowledge
  output reg wb_err_o, // Wishbone error for unmapped addresses
  output reg system_reset, // Reset request to the system, high active
  output reg timeout_pulse, // One-cycle pulse at each time-out
  output reg irq // Level interrupt, unmasked status set
);

  // Control register fields
  reg watchdog_enable_bit; // Enable
  reg watchdog_restart_bit; // Pending restart, self clearing
  reg idle_run_enable; // Keep running in idle
  reg [2:0] prescale_select; // Ratio code
  // Interrupt status and mask
  reg [1:0] event_status; // Sticky events
  reg [1:0] event_mask; // Enables of events
  // Main counter
  reg [`WDOG_COUNT_BITS-1:0] wd_count; // 14-bit time-out counter
  reg [7:0] reset_hold; // Remaining clocks of reset pulse
  reg restart_done; // Restart applied this cycle

  wire running; // Watchdog advancing
  wire tick; // Instruction-cycle enable
  wire presc_pulse; // Selected divider output
  wire overflow; // Counter leaves all ones
  wire bus_req; // Active bus request not yet answered
  wire [9:0] word_addr; // Address without byte offset
  wire hit_ctrl; // Control register selected
  wire hit_stat; // Status register selected
  wire hit_mask; // Mask register selected
  wire hit_count; // Counter register selected
  wire mapped; // Any register selected
  wire wr_lane0; // Write to lane 0
  wire [1:0] stat_set; // Events this cycle
  wire [1:0] stat_clr; // Write-one-to-clear mask
  wire [7:0] ctrl_read; // Control register readback
  reg [31:0] next_rdata; // Read mux output

  // Running only when enabled and, in idle, allowed
  assign running = watchdog_enable_bit & (~idle_mode | idle_run_enable);

  // Overflow when the selected tap fires with counter at all ones
  assign overflow = running & presc_pulse & (&wd_count);

  // Instruction-cycle enable, 12 clocks per tick
  tick_divider u_tick (
    .mclk(mclk),
    .resetn(resetn),
    .run(running),
    .tick(tick)
  );

  // Prescaler; restart clears it along with the counter
  prescale_divider u_presc (
    .mclk(mclk),
    .resetn(resetn),
    .clear(restart_done),
    .advance(running & tick),
    .select(prescale_select),
    .pulse(presc_pulse)
  );

  // Bus decode, one register word per aligned address
  assign bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~wb_err_o;
  assign word_addr = wb_adr_i[11:2];
  assign hit_ctrl = ({word_addr, 2'b00} == {2'b00, `WDOG_CTRL_ADDR});
  assign hit_stat = ({word_addr, 2'b00} == {2'b00, `WDOG_STAT_ADDR});
  assign hit_mask = ({word_addr, 2'b00} == {2'b00, `WDOG_MASK_ADDR});
  assign hit_count = ({word_addr, 2'b00} == {2'b00, `WDOG_COUNT_ADDR});
  assign mapped = hit_ctrl | hit_stat | hit_mask | hit_count;
  assign wr_lane0 = bus_req & wb_we_i & wb_sel_i[0];

  // Bits 4 and 3 read as zero
  assign ctrl_read = {watchdog_enable_bit, watchdog_restart_bit, idle_run_enable,
                      2'b00, prescale_select};

  // Read data multiplexer
  always @* begin
    next_rdata = 32'h00000000;
    if (hit_ctrl) begin
      next_rdata = {24'h000000, ctrl_read};
    end else if (hit_stat) begin
      next_rdata = {30'h00000000, event_status};
    end else if (hit_mask) begin
      next_rdata = {30'h00000000, event_mask};
    end else if (hit_count) begin
      next_rdata = {18'h00000, wd_count};
    end
  end

  // Bus answer: one wait state, ack or err, dropped the next cycle
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      wb_ack_o <= 1'b0;
      wb_err_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= bus_req & mapped;
      wb_err_o <= bus_req & ~mapped; // Unmapped address answered with error
      if (bus_req & ~wb_we_i & mapped) begin
        wb_dat_o <= next_rdata;
      end
    end
  end

  // Control register; reset disables the watchdog
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      watchdog_enable_bit <= 1'b0;
      watchdog_restart_bit <= 1'b0;
      idle_run_enable <= 1'b0;
      prescale_select <= 3'h0;
    end else begin
      if (wr_lane0 & hit_ctrl) begin
        watchdog_enable_bit <= wb_dat_i[`WDOG_ENABLE_BIT];
        idle_run_enable <= wb_dat_i[`WDOG_IDLE_RUN_BIT];
        prescale_select <= wb_dat_i[`WDOG_SEL_MSB:`WDOG_SEL_LSB];
      end
      // A new write of one wins over the automatic clear
      if (wr_lane0 & hit_ctrl & wb_dat_i[`WDOG_RESTART_BIT]) begin
        watchdog_restart_bit <= 1'b1;
      end else if (restart_done) begin
        watchdog_restart_bit <= 1'b0;
      end
    end
  end

  // Restart lands on the next instruction-cycle boundary
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      restart_done <= 1'b0;
    end else begin
      // When stopped there is no tick, so apply at once
      restart_done <= watchdog_restart_bit & ~restart_done & (tick | ~running);
    end
  end

  // Time-out counter advanced by the prescaler output
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      wd_count <= 14'h0000;
    end else if (restart_done) begin
      wd_count <= 14'h0000;
    end else if (running & presc_pulse) begin
      wd_count <= wd_count + 14'h0001;
    end
  end

  // Reset request pulse after a time-out; the system reset returns on resetn
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      reset_hold <= 8'h00;
      system_reset <= 1'b0;
      timeout_pulse <= 1'b0;
    end else begin
      timeout_pulse <= overflow;
      if (overflow & watchdog_enable_bit) begin
        reset_hold <= `WDOG_RESET_PULSE;
        system_reset <= 1'b1;
      end else if (reset_hold != 8'h00) begin
        reset_hold <= reset_hold - 8'h01;
        system_reset <= (reset_hold != 8'h01);
      end else begin
        system_reset <= 1'b0;
      end
    end
  end

  // Sticky events; set wins over a write-one clear
  assign stat_set = {restart_done, overflow};
  assign stat_clr = (wr_lane0 & hit_stat) ? wb_dat_i[1:0] : 2'b00;

  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      event_status <= 2'h0;
      event_mask <= `WDOG_MASK_RESET;
      irq <= 1'b0;
    end else begin
      event_status <= (event_status & ~stat_clr) | stat_set;
      if (wr_lane0 & hit_mask) begin
        event_mask <= wb_dat_i[1:0];
      end
      irq <= |(((event_status & ~stat_clr) | stat_set) & event_mask);
    end
  end
endmodule // watchdog_timer

// ===== watchdog_timer_sva.sv
// Bus and reset-output assertions for the watchdog block
module watchdog_timer_sva (
  input wire logic mclk, // System clock
  input wire logic resetn, // Reset, active low
  input wire logic wb_cyc_i, // Bus cycle
  input wire logic wb_stb_i, // Bus strobe
  input wire logic wb_we_i, // Bus write
  input wire logic [11:0] wb_adr_i, // Bus address
  input wire logic [31:0] wb_dat_o, // Read data
  input wire logic wb_ack_o, // Acknowledge
  input wire logic wb_err_o, // Error
  input wire logic system_reset, // Reset request
  input wire logic timeout_pulse // Overflow pulse
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);
  // Request taken only when nothing is outstanding
  sequence req_s;
    wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
  endsequence
  // Register word numbers that decode
  wire mapped = wb_adr_i[11:2] inside {10'h08F, 10'h090, 10'h091, 10'h092};
  a_one_answer: assert property (req_s |=> wb_ack_o ^ wb_err_o)
    else $error("request not answered by exactly one of ack or err");
  a_err_unmapped: assert property (req_s ##0 !mapped |=> wb_err_o)
    else $error("unmapped access not refused");
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_no_spurious: assert property (!wb_stb_i |=> !wb_ack_o && !wb_err_o)
    else $error("answer without request");
  a_rd_upper: assert property (wb_ack_o && !wb_we_i |-> wb_dat_o[31:14] == 18'h0)
    else $error("upper read bits not zero");
  a_ctrl_gap: assert property (wb_ack_o && !wb_we_i && wb_adr_i[11:2] == 10'h08F |->
    wb_dat_o[4:3] == 2'h0) else $error("control bits 4:3 not zero");
  a_tmo_single: assert property (timeout_pulse |=> !timeout_pulse)
    else $error("overflow pulse longer than one cycle");
  a_rst_cause: assert property ($rose(system_reset) |-> timeout_pulse)
    else $error("system reset without overflow");
  a_rst_hold: assert property ($rose(system_reset) |-> system_reset [*8])
    else $error("system reset pulse too short");
endmodule // watchdog_timer_sva

bind watchdog_timer watchdog_timer_sva u_sva (.mclk(mclk), .resetn(resetn),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o),
  .system_reset(system_reset), .timeout_pulse(timeout_pulse));

// ===== watchdog_timer_test.sv
// Register-level testbench for the watchdog block
module watchdog_timer_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk = 0, resetn = 0, idle_mode = 0, cyc = 0, stb = 0, we = 0, lerr; // Drives
  logic [11:0] adr = 12'h000; // Bus address
  logic [31:0] wdat = 32'h0, rdat, q; // Bus data
  logic ack, err, sys_rst, tmo, irq; // Outputs
  int bad_count = 0, cmp_count = 0, i;
  int ratio[8] = '{2, 8, 4, 16, 32, 64, 128, 256}; // Ratio by select code
  localparam logic [11:0] C = 12'h23C, S = 12'h240, M = 12'h244, K = 12'h248;
  watchdog_timer DUT (.mclk(mclk), .resetn(resetn), .idle_mode(idle_mode), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .wb_err_o(err), .system_reset(sys_rst),
    .timeout_pulse(tmo), .irq(irq));
  // Free-running 100 MHz clock
  initial begin
    forever #5 mclk = ~mclk;
  end
  task automatic tally_and_finish;
    if (bad_count == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      bad_count++;
      $display("unexpected at %0t got %h exp %h", $time, g, e);
    end
  endtask
  // Counter readings land in a window, since the instruction-cycle divider phase is free
  task automatic rng(input logic [31:0] g, input int lo, input int hi);
    chk({31'h0, (g >= lo && g <= hi)}, 32'h1);
  endtask
  // One classic cycle; held until ack or err is seen, bounded wait
  task automatic bus(input logic [11:0] a, input logic w, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge mclk);
    cyc <= 1; stb <= 1; we <= w; adr <= a; wdat <= d;
    do begin
      @(posedge mclk);
      n++;
    end while (ack !== 1'b1 && err !== 1'b1 && n < 20);
    q = rdat; lerr = err;
    cyc <= 0; stb <= 0; we <= 0;
    if (n >= 20) begin
      bad_count++;
      tally_and_finish;
    end
  endtask
  // Main sequence
  initial begin
    repeat (8) @(posedge mclk);
    resetn <= 1;
    bus(C, 0, 0); chk(q, 32'h0);
    bus(K, 0, 0); chk(q, 32'h0);
    bus(M, 0, 0); chk(q, 32'h0);
    bus(12'h300, 0, 0); chk({31'h0, lerr}, 32'h1);
    bus(C, 1, 32'hFF); repeat (20) @(posedge mclk);
    bus(C, 0, 0); chk(q, 32'hA7);
    for (i = 0; i < 8; i++) begin
      bus(C, 1, 32'hC0 | i); repeat (48 * ratio[i]) @(posedge mclk);
      bus(K, 0, 0); rng(q, 3, 4);
      bus(C, 0, 0); chk(q, 32'h80 | i);
      chk({30'h0, sys_rst, tmo}, 32'h0);
    end
    bus(C, 1, 32'h40); repeat (30) @(posedge mclk);
    bus(K, 0, 0); chk(q, 32'h0);
    repeat (300) @(posedge mclk);
    bus(K, 0, 0); chk(q, 32'h0);
    bus(C, 1, 32'h80); idle_mode <= 1; repeat (300) @(posedge mclk);
    bus(K, 0, 0); chk(q, 32'h0);
    bus(C, 1, 32'hA0); repeat (240) @(posedge mclk);
    bus(K, 0, 0); rng(q, 8, 10);
    idle_mode <= 0;
    bus(M, 1, 32'h2); bus(C, 1, 32'h40); repeat (5) @(posedge mclk);
    chk({31'h0, irq}, 32'h1);
    bus(S, 0, 0); chk(q, 32'h2);
    bus(S, 1, 32'h2); repeat (3) @(posedge mclk);
    chk({31'h0, irq}, 32'h0);
    bus(M, 1, 32'h0); bus(C, 1, 32'h40); repeat (5) @(posedge mclk);
    chk({31'h0, irq}, 32'h0);
    bus(S, 0, 0); chk(q, 32'h2);
    bus(C, 1, 32'hC0); repeat (500) @(posedge mclk);
    resetn <= 0; repeat (8) @(posedge mclk);
    resetn <= 1;
    bus(C, 0, 0); chk(q, 32'h0);
    bus(K, 0, 0); chk(q, 32'h0);
    chk({30'h0, sys_rst, tmo}, 32'h0);
    tally_and_finish;
  end
endmodule // watchdog_timer_test
